/* timer8_counter_compare_unit.sv */
// Contract
// - count and compare registers are 8 bits
// - every request flagged and individually maskable
// - source zero stops ticks; counter still accessible
// - tick from io clock or crystal when async
// - signal bottom at 0x00, max at 0xff
// - top is 0xff or compare value by mode
// - each tick clears, increments or decrements counter
// - cpu counter write beats count or clear
// - mode bits set sequence and overflow point
// - overflow flag can request interrupt
// - match sets compare flag on next tick
// - enabled flag requests irq, clears on service
// - writing one clears match flag
// - waveform from match, mode, action, max, bottom
// - pwm modes buffer compare, update top/bottom
// - cpu reaches buffer or working compare register
// - force strobe acts like match in non-pwm modes only, no flag
// - counter write blocks match on next tick
// - output state kept across mode changes
// - action bits take effect immediately
// - action bits pick output and pin source
// - mode 0 normal: up, wrap, no clear
// - mode 2 clears counter on compare
// - mode 3 fast pwm single slope
// - action zero leaves output unchanged
`default_nettype none
module timer8_counter_compare_unit #(
	parameter int prescale_max = 1024 // largest io clock divider
) (
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	input  wire logic                      clk_en,
	input  wire timer8_pkg::reg_req_type   reg_req,
	output logic [7:0]                     reg_rdata,
	input  wire logic                      crystal_in_pin,
	input  wire logic                      crystal_osc,
	input  wire logic                      overflow_irq_ack,
	input  wire logic                      match_irq_ack,
	output logic                           overflow_irq,
	output logic                           match_irq,
	output logic                           compare_output,
	output logic                           compare_output_en
);
	initial begin
		if (prescale_max < 8 || prescale_max > 65536)
			$error("prescale_max out of range");
	end

	// register state
	logic [7:0] count_value_q;        // live counter
	logic [7:0] compare_value_q;      // working compare value
	logic [7:0] compare_buffer_q;     // cpu-side buffer in pwm modes
	logic [7:0] timer_control_a_q;    // mode and action bits
	logic [2:0] clock_source_select_q;
	logic [1:0] timer_flag_q;         // overflow, match
	logic [1:0] timer_mask_q;
	logic [1:0] async_status_q;       // async select, direct crystal
	logic       compare_output_q;     // internal output state
	logic       count_down_q;         // direction in phase correct mode
	logic       block_match_q;        // pending match blocker
	logic       match_pend_q;         // match seen, flag on next tick
	logic [15:0] prescale_q;          // io clock divider
	logic [2:0] xtal_sync_q;          // crystal edge sync
	logic       rd_pend_q;

	// decoded fields
	timer8_pkg::wave_mode_type wave_mode;
	logic [1:0] compare_output_action;
	logic       pwm_mode;
	logic [7:0] top_val;
	logic       at_bottom;
	logic       at_max;
	logic       at_top;
	logic       match;
	logic       timer_tick;
	logic       io_tick;
	logic       xtal_tick;
	logic       cnt_wr;
	logic       force_wr;
	logic       xtal_src;

	assign wave_mode = timer8_pkg::wave_mode_type'(
		timer_control_a_q[timer8_pkg::wave_lsb +: 2]);
	assign compare_output_action = timer_control_a_q[timer8_pkg::action_lsb +: 2];
	assign pwm_mode  = wave_mode == timer8_pkg::wave_phase || wave_mode == timer8_pkg::wave_fast;
	assign at_bottom = count_value_q == timer8_pkg::bottom_val;
	assign at_max    = count_value_q == timer8_pkg::max_val;
	// only clear-on-compare and phase correct use the stored value as top
	assign top_val = (wave_mode == timer8_pkg::wave_clear || wave_mode == timer8_pkg::wave_phase)
		? compare_value_q : timer8_pkg::max_val;
	assign at_top = count_value_q == top_val;
	// comparator runs always; blocker masks it
	assign match  = (count_value_q == compare_value_q) && !block_match_q;
	assign cnt_wr = reg_req.wr && reg_req.addr == timer8_pkg::count_value_off;
	assign force_wr = reg_req.wr && reg_req.addr == timer8_pkg::control_b_off
		&& reg_req.wdata[timer8_pkg::force_bit];
	assign xtal_src = async_status_q[timer8_pkg::async_sel_bit];

	// decode a source select into an io divider tap
	function automatic logic io_tap(input logic [2:0] sel, input logic [15:0] pre);
		case (sel)
			3'h1:    io_tap = 1'b1;
			3'h2:    io_tap = pre[2:0] == 3'h7;
			3'h3:    io_tap = pre[4:0] == 5'h1f;
			3'h4:    io_tap = pre[5:0] == 6'h3f;
			3'h5:    io_tap = pre[6:0] == 7'h7f;
			3'h6:    io_tap = pre[7:0] == 8'hff;
			3'h7:    io_tap = pre[9:0] == 10'h3ff;
			default: io_tap = 1'b0; // stopped
		endcase
	endfunction

	// free running io clock prescaler
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_q <= 16'h0000;
		end else if (clk_en) begin
			prescale_q <= prescale_q + 16'h0001;
		end
	end

	// crystal sampled into ref_clk: two stages then edge detect
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xtal_sync_q <= 3'h0;
		end else if (clk_en) begin
			xtal_sync_q <= {xtal_sync_q[1:0],
				async_status_q[timer8_pkg::xtal_direct_bit] ? crystal_in_pin : crystal_osc};
		end
	end

	assign io_tick   = io_tap(clock_source_select_q, prescale_q);
	// crystal ticks once per rising edge; source select still gates it
	assign xtal_tick = xtal_sync_q[1] && !xtal_sync_q[2] && clock_source_select_q != 3'h0;
	// tick source mux
	assign timer_tick = xtal_src ? xtal_tick : io_tick;

	// counter unit
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_value_q <= timer8_pkg::reg_reset;
		end else if (clk_en) begin
			if (cnt_wr) begin
				// cpu write wins over any tick action
				count_value_q <= reg_req.wdata;
			end else if (timer_tick) begin
				case (wave_mode)
					timer8_pkg::wave_normal:
						count_value_q <= count_value_q + 8'h01; // wraps
					timer8_pkg::wave_clear:
						count_value_q <= (count_value_q == compare_value_q)
							? timer8_pkg::bottom_val : count_value_q + 8'h01;
					timer8_pkg::wave_fast:
						count_value_q <= at_max
							? timer8_pkg::bottom_val : count_value_q + 8'h01;
					timer8_pkg::wave_phase: begin
						// turn at top and bottom
						if (count_down_q)
							count_value_q <= at_bottom ? count_value_q + 8'h01
								: count_value_q - 8'h01;
						else
							count_value_q <= at_top ? count_value_q - 8'h01
								: count_value_q + 8'h01;
					end
					default: count_value_q <= count_value_q;
				endcase
			end
		end
	end

	// direction for dual slope
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_down_q <= 1'b0;
		end else if (clk_en) begin
			if (wave_mode != timer8_pkg::wave_phase) begin
				count_down_q <= 1'b0;
			end else if (timer_tick && !cnt_wr) begin
				if (!count_down_q && at_top)
					count_down_q <= 1'b1;
				else if (count_down_q && at_bottom)
					count_down_q <= 1'b0;
			end
		end
	end

	// blocker: set by counter write, released by the following tick
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			block_match_q <= 1'b0;
		end else if (clk_en) begin
			if (cnt_wr)
				block_match_q <= 1'b1; // holds even when stopped
			else if (timer_tick)
				block_match_q <= 1'b0;
		end
	end

	// match is latched and turns into the flag on the next tick
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			match_pend_q <= 1'b0;
		end else if (clk_en) begin
			if (timer_tick)
				match_pend_q <= 1'b0;
			else if (match)
				match_pend_q <= 1'b1;
			if (cnt_wr)
				match_pend_q <= 1'b0;
		end
	end

	// compare value: buffered in pwm modes, direct otherwise
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compare_value_q  <= timer8_pkg::reg_reset;
			compare_buffer_q <= timer8_pkg::reg_reset;
		end else if (clk_en) begin
			if (reg_req.wr && reg_req.addr == timer8_pkg::compare_value_off) begin
				compare_buffer_q <= reg_req.wdata;
				if (!pwm_mode)
					compare_value_q <= reg_req.wdata; // bypass
			end
			// fast pwm loads at bottom, phase correct at top
			if (pwm_mode && timer_tick) begin
				if ((wave_mode == timer8_pkg::wave_fast && at_max)
					|| (wave_mode == timer8_pkg::wave_phase && at_top && !count_down_q))
					compare_value_q <= compare_buffer_q;
			end
		end
	end

	// waveform generator; state survives mode changes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compare_output_q <= 1'b0;
		end else if (clk_en) begin
			// action bits read live
			if (!pwm_mode && (force_wr || (timer_tick && match))) begin
				case (compare_output_action)
					2'h1:    compare_output_q <= !compare_output_q;
					2'h2:    compare_output_q <= 1'b0;
					2'h3:    compare_output_q <= 1'b1;
					default: compare_output_q <= compare_output_q;
				endcase
			end else if (pwm_mode && timer_tick && compare_output_action[1]) begin
				if (wave_mode == timer8_pkg::wave_fast) begin
					// clear or set on match, opposite at bottom
					if (at_max)
						compare_output_q <= !compare_output_action[0];
					else if (match)
						compare_output_q <= compare_output_action[0];
				end else if (match) begin
					// up-count match vs down-count match
					compare_output_q <= count_down_q ^ compare_output_action[0];
				end
			end
		end
	end

	// flags: hardware set wins over software or service clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_flag_q <= 2'b00;
		end else if (clk_en) begin
			if (reg_req.wr && reg_req.addr == timer8_pkg::timer_flag_off)
				timer_flag_q <= timer_flag_q & ~reg_req.wdata[1:0];
			if (overflow_irq_ack)
				timer_flag_q[timer8_pkg::overflow_bit] <= 1'b0;
			if (match_irq_ack)
				timer_flag_q[timer8_pkg::match_bit] <= 1'b0;
			// overflow point by mode
			if (timer_tick && !cnt_wr) begin
				if ((wave_mode == timer8_pkg::wave_phase && count_down_q && at_bottom)
					|| (wave_mode != timer8_pkg::wave_phase && at_max))
					timer_flag_q[timer8_pkg::overflow_bit] <= 1'b1;
			end
			// a match standing at the tick counts too: with no prescaling every
			// cycle is a tick and the pending latch would never fill
			if (timer_tick && (match_pend_q || match))
				timer_flag_q[timer8_pkg::match_bit] <= 1'b1;
		end
	end

	// control, mask and async registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_control_a_q     <= timer8_pkg::reg_reset;
			clock_source_select_q <= 3'h0;
			timer_mask_q          <= 2'b00;
			async_status_q        <= 2'b00;
		end else if (clk_en && reg_req.wr) begin
			if (reg_req.addr == timer8_pkg::control_a_off)
				timer_control_a_q <= reg_req.wdata & 8'h33;
			else if (reg_req.addr == timer8_pkg::control_b_off)
				clock_source_select_q <= reg_req.wdata[timer8_pkg::clk_sel_lsb +: 3];
			else if (reg_req.addr == timer8_pkg::timer_mask_off)
				timer_mask_q <= reg_req.wdata[1:0];
			else if (reg_req.addr == timer8_pkg::async_status_off)
				async_status_q <= reg_req.wdata[1:0];
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
			rd_pend_q <= 1'b0;
		end else if (clk_en) begin
			rd_pend_q <= reg_req.rd;
			if (!reg_req.rd)
				reg_rdata <= 8'h00;
			else if (reg_req.addr == timer8_pkg::count_value_off)
				reg_rdata <= count_value_q;
			else if (reg_req.addr == timer8_pkg::compare_value_off)
				reg_rdata <= pwm_mode ? compare_buffer_q : compare_value_q;
			else if (reg_req.addr == timer8_pkg::timer_flag_off)
				reg_rdata <= {6'h00, timer_flag_q};
			else if (reg_req.addr == timer8_pkg::timer_mask_off)
				reg_rdata <= {6'h00, timer_mask_q};
			else if (reg_req.addr == timer8_pkg::control_a_off)
				reg_rdata <= timer_control_a_q;
			else if (reg_req.addr == timer8_pkg::control_b_off)
				reg_rdata <= {5'h00, clock_source_select_q};
			else if (reg_req.addr == timer8_pkg::async_status_off)
				reg_rdata <= {6'h00, async_status_q};
			else
				reg_rdata <= 8'h00; // unmapped reads zero
		end
	end

	// requests gated by mask
	assign overflow_irq = timer_flag_q[timer8_pkg::overflow_bit]
		&& timer_mask_q[timer8_pkg::overflow_bit];
	assign match_irq = timer_flag_q[timer8_pkg::match_bit] && timer_mask_q[timer8_pkg::match_bit];
	// pin takes the output whenever any action bit is set
	assign compare_output    = compare_output_q;
	assign compare_output_en = compare_output_action != 2'h0;
endmodule // timer8_counter_compare_unit
`default_nettype wire

/* timer8_pkg.sv */
`default_nettype none
package timer8_pkg;
	// register offsets (byte addresses on the plain register port)
	localparam logic [3:0] count_value_off   = 4'h0;
	localparam logic [3:0] compare_value_off = 4'h1;
	localparam logic [3:0] timer_flag_off    = 4'h2;
	localparam logic [3:0] timer_mask_off    = 4'h3;
	localparam logic [3:0] control_a_off     = 4'h4;
	localparam logic [3:0] control_b_off     = 4'h5;
	localparam logic [3:0] async_status_off  = 4'h6;
	localparam logic [3:0] irq_ack_off       = 4'h7;

	// field positions
	localparam int wave_lsb       = 0;  // control a [1:0]
	localparam int action_lsb     = 4;  // control a [5:4]
	localparam int clk_sel_lsb    = 0;  // control b [2:0]
	localparam int force_bit      = 7;  // control b, strobe
	localparam int overflow_bit   = 0;  // flag / mask
	localparam int match_bit      = 1;  // flag / mask
	localparam int async_sel_bit  = 0;  // async status
	localparam int xtal_direct_bit = 1; // async status

	// reset value and counter limits
	localparam logic [7:0] reg_reset = 8'h00;
	localparam logic [7:0] bottom_val = 8'h00;
	localparam logic [7:0] max_val    = 8'hff;

	typedef enum logic [1:0] {
		wave_normal  = 2'b00,
		wave_phase   = 2'b01,
		wave_clear   = 2'b10,
		wave_fast    = 2'b11
	} wave_mode_type;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;
endpackage
`default_nettype wire

/* timer8_chk.sv */
`default_nettype none
module timer8_chk #(
	parameter int prescale_max = 1024 // handed on from the unit
) (
	input wire logic                    ref_clk,
	input wire logic                    reset_n,
	input wire logic                    clk_en,
	input wire timer8_pkg::reg_req_type reg_req,
	input wire logic [7:0]              reg_rdata,
	input wire logic                    crystal_in_pin,
	input wire logic                    crystal_osc,
	input wire logic                    overflow_irq_ack,
	input wire logic                    match_irq_ack,
	input wire logic                    overflow_irq,
	input wire logic                    match_irq,
	input wire logic                    compare_output,
	input wire logic                    compare_output_en
);
	logic [1:0] act_q;  // shadow of action bits
	logic [1:0] wav_q;  // shadow of wave mode
	logic [1:0] msk_q;  // shadow of mask bits
	logic [2:0] src_q;  // shadow of clock source
	logic       stop_q; // source was zero last cycle
	wire logic  wr_en = clk_en && reg_req.wr;
	wire logic  wr_b  = wr_en && reg_req.addr == timer8_pkg::control_b_off;
	wire logic  wr_m  = wr_en && reg_req.addr == timer8_pkg::timer_mask_off;
	// quiet needs two stopped cycles so a tick already in flight is excluded
	wire logic  quiet = stop_q && src_q == 3'h0;

	// shadow the control fields as software writes them
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			act_q  <= 2'h0;
			wav_q  <= 2'h0;
			msk_q  <= 2'h0;
			src_q  <= 3'h0;
			stop_q <= 1'b1;
		end else begin
			stop_q <= src_q == 3'h0;
			if (wr_en && reg_req.addr == timer8_pkg::control_a_off) begin
				act_q <= reg_req.wdata[5:4];
				wav_q <= reg_req.wdata[1:0];
			end
			if (wr_m) begin
				msk_q <= reg_req.wdata[1:0];
			end
			if (wr_b) begin
				src_q <= reg_req.wdata[2:0];
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_rdata_idle_zero: assert property (clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_ctrl_readback: assert property (clk_en && reg_req.rd
		&& reg_req.addr == timer8_pkg::control_a_off
		|=> reg_rdata == {2'h0, act_q, 2'h0, wav_q})
		else $error("control a readback wrong");
	a_unmapped_zero: assert property (clk_en && reg_req.rd
		&& reg_req.addr == timer8_pkg::irq_ack_off |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_pin_source: assert property (compare_output_en == (act_q != 2'h0))
		else $error("output enable disagrees with action bits");
	a_match_masked: assert property (match_irq |-> msk_q[timer8_pkg::match_bit])
		else $error("match request while masked");
	a_ovf_masked: assert property (overflow_irq |-> msk_q[timer8_pkg::overflow_bit])
		else $error("overflow request while masked");
	a_ack_clears: assert property (clk_en && match_irq_ack && quiet && !wr_b |=> !match_irq)
		else $error("service did not clear match flag");
	a_flag_write_clear: assert property (wr_en && reg_req.addr == timer8_pkg::timer_flag_off
		&& reg_req.wdata[timer8_pkg::match_bit] && quiet |=> !match_irq)
		else $error("write one did not clear match flag");
	a_stop_hold: assert property (quiet && !wr_b && !$past(wr_b) |=> $stable(compare_output))
		else $error("output moved while stopped");
	a_stop_no_flag: assert property (quiet && !wr_m
		|=> !$rose(match_irq) && !$rose(overflow_irq))
		else $error("flag set while stopped");

	c_match: cover property (match_irq);
	c_overflow: cover property (overflow_irq);
	c_output_rise: cover property (compare_output_en && $rose(compare_output));
endmodule // timer8_chk

bind timer8_counter_compare_unit timer8_chk #(.prescale_max(prescale_max)) chk_inst (
	.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .crystal_in_pin(crystal_in_pin), .crystal_osc(crystal_osc),
	.overflow_irq_ack(overflow_irq_ack), .match_irq_ack(match_irq_ack),
	.overflow_irq(overflow_irq), .match_irq(match_irq), .compare_output(compare_output),
	.compare_output_en(compare_output_en));
`default_nettype wire

/* timer8_counter_compare_unit_bench.sv */
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end
module timer8_counter_compare_unit_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] o_cnt = timer8_pkg::count_value_off;
	localparam logic [3:0] o_cmp = timer8_pkg::compare_value_off;
	localparam logic [3:0] o_flg = timer8_pkg::timer_flag_off;
	localparam logic [3:0] o_msk = timer8_pkg::timer_mask_off;
	localparam logic [3:0] o_cta = timer8_pkg::control_a_off;
	localparam logic [3:0] o_ctb = timer8_pkg::control_b_off;
	localparam logic [3:0] o_asy = timer8_pkg::async_status_off;
	// non-pwm force table: action code and resulting output
	localparam logic [1:0] fa [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
	localparam logic       fo [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic                    ref_clk = 1'b0;
	logic                    reset_n = 1'b0;
	logic                    clk_en = 1'b1;
	logic                    crystal_in_pin = 1'b0;
	logic                    crystal_osc = 1'b0;
	logic                    overflow_irq_ack = 1'b0;
	logic                    match_irq_ack = 1'b0;
	timer8_pkg::reg_req_type req = '0;
	logic [7:0]              reg_rdata;
	logic                    overflow_irq;
	logic                    match_irq;
	logic                    compare_output;
	logic                    compare_output_en;
	int                      n_errors = 0;
	int                      total_checks = 0;

	timer8_counter_compare_unit timer8_counter_compare_unit_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_req(req),
		.reg_rdata(reg_rdata), .crystal_in_pin(crystal_in_pin), .crystal_osc(crystal_osc),
		.overflow_irq_ack(overflow_irq_ack), .match_irq_ack(match_irq_ack),
		.overflow_irq(overflow_irq), .match_irq(match_irq),
		.compare_output(compare_output), .compare_output_en(compare_output_en));

	// 100 ns reference clock
	always #50 ref_clk = ~ref_clk;
	// crystal runs free and unrelated in phase
	always #1530 crystal_osc = ~crystal_osc;

	task automatic tally_and_finish();
		if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// one-cycle write strobe, released at the taking edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req <= '0;
		#1 d = reg_rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	// bounded wait for a request line; running out ends the run
	task automatic wait_irq(input logic m);
		int i;
		for (i = 0; i < 600; i++) begin
			@(posedge ref_clk);
			#1;
			if ((m ? match_irq : overflow_irq) === 1'b1) break;
		end
		if (i == 600) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	// hang guard
	initial begin
		#3000000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		logic [7:0] d;
		int         ones;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8; a++) rchk(a[3:0], 8'h00);
		wr(o_cmp, 8'ha5); rchk(o_cmp, 8'ha5);
		wr(o_cnt, 8'h3c); rchk(o_cnt, 8'h3c);
		wr(o_cta, 8'hff); rchk(o_cta, 8'h33);
		wr(4'h7, 8'hff); rchk(4'h7, 8'h00);
		// output state set by force under each action code, after the pin enable is checked
		for (int i = 0; i < 6; i++) begin
			wr(o_cta, {2'h0, fa[i], 4'h0});
			`CHK(compare_output_en, fa[i] != 2'h0)
			wr(o_ctb, 8'h80);
			repeat (2) @(posedge ref_clk);
			#1 `CHK(compare_output, fo[i])
		end
		rchk(o_flg, 8'h00);
		wr(o_cta, 8'h03); wr(o_cta, 8'h01); wr(o_cta, 8'h00);
		`CHK(compare_output, 1'b1)
		// overflow in normal mode, then serviced
		wr(o_msk, 8'h03); wr(o_cnt, 8'hf0); wr(o_ctb, 8'h01);
		wait_irq(1'b0);
		wr(o_ctb, 8'h00);
		rchk(o_flg, 8'h01);
		rd(o_cnt, d); `CHK(d < 8'h10, 1'b1)
		@(posedge ref_clk) overflow_irq_ack <= 1'b1;
		@(posedge ref_clk) overflow_irq_ack <= 1'b0;
		#1 `CHK(overflow_irq, 1'b0)
		// compare match, no clear in normal mode
		wr(o_cmp, 8'h20); wr(o_cnt, 8'h10); wr(o_ctb, 8'h01);
		wait_irq(1'b1);
		wr(o_ctb, 8'h00);
		rd(o_cnt, d); `CHK(d > 8'h20 && d < 8'h28, 1'b1)
		wr(o_flg, 8'h00); rchk(o_flg, 8'h02);
		wr(o_flg, 8'h02); rchk(o_flg, 8'h00);
		// counter written equal to compare: first match suppressed
		wr(o_cmp, 8'h30); wr(o_cnt, 8'h30); wr(o_ctb, 8'h01);
		repeat (20) @(posedge ref_clk);
		wr(o_ctb, 8'h00); rchk(o_flg, 8'h00);
		// clear-on-compare never passes the compare value
		wr(o_cta, 8'h02); wr(o_cmp, 8'h08); wr(o_cnt, 8'h00); wr(o_ctb, 8'h01);
		for (int i = 0; i < 12; i++) begin
			rd(o_cnt, d); `CHK(d <= 8'h08, 1'b1)
		end
		wr(o_ctb, 8'h00); rchk(o_flg, 8'h02);
		// fast pwm non-inverting: a quarter duty once the buffer loads
		wr(o_cta, 8'h23); wr(o_cmp, 8'h40); wr(o_flg, 8'h03); wr(o_ctb, 8'h01);
		wait_irq(1'b0);
		ones = 0;
		for (int i = 0; i < 512; i++) begin
			@(posedge ref_clk);
			#1 if (compare_output === 1'b1) ones++;
		end
		`CHK(ones >= 120 && ones <= 136, 1'b1)
		wr(o_ctb, 8'h00);
		// phase correct turns at the stored top and never passes it
		wr(o_cta, 8'h01); wr(o_cnt, 8'h00); wr(o_ctb, 8'h01);
		for (int i = 0; i < 40; i++) begin
			rd(o_cnt, d); `CHK(d <= 8'h40, 1'b1)
		end
		wr(o_ctb, 8'h00);
		// crystal clocking: far fewer ticks than the io clock gives
		wr(o_asy, 8'h01); rchk(o_asy, 8'h01);
		wr(o_cta, 8'h00); wr(o_cnt, 8'h00); wr(o_ctb, 8'h01);
		repeat (100) @(posedge ref_clk);
		wr(o_ctb, 8'h00);
		rd(o_cnt, d); `CHK(d >= 8'h02 && d <= 8'h06, 1'b1)
		tally_and_finish();
	end
endmodule // timer8_counter_compare_unit_bench
`undef CHK
`default_nettype wire
